// ---- rtl/acm_pkg.sv ----
// Shared constants, types and slot helpers for the modem AC-link slot payloads
// Functional notes
// RULE_01 - Read data in slot 2 bits 19:4, zero if invalid
// RULE_02 - Slot 2 bits 3:0 always zero
// RULE_03 - Modem ADC sample in slot 5, MSB at 19
// RULE_04 - Slots 5, 11, 12 bits 3:0 zero
// RULE_05 - Single-line modem codec using slots 5 and 12
// RULE_06 - Handset ADC sample in slot 11, MSB at 19
// RULE_07 - Slot 12 reports sampled input pins every frame
// RULE_08 - Output pins report last commanded level
// RULE_09 - Controller debounces reported pin states itself
// RULE_10 - Status bits 19:12 have no pin, read zero
// RULE_11 - Bits 4-7 internal line signals, bit 11 reserved
// RULE_12 - Bits 8-10 are companion external pins
// RULE_13 - Slot 1 bit 19: one read, zero write
// RULE_14 - Slot 1 bits 18:12 carry register index
// RULE_15 - Controller zeros slot 1 bits 11:0
// RULE_16 - Write data in slot 2 stored in register
// RULE_17 - Read command: controller zeros whole slot 2
// RULE_18 - DAC sample in slot 5 bits 19:4
// RULE_19 - Write data in bits 19:4, low zeros
// RULE_20 - Read result returns exactly one frame later
// RULE_21 - Tags 1 and 2 set only for read result
// RULE_22 - Slot 1 echoes returned index, else zero
// RULE_23 - Output pins follow slot 12 control bits
package acm_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int PCLK_PERIOD_NS = 10;
  localparam int BCLK_PERIOD_NS = 160;
  localparam int BCLK_HALF = BCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF - 1);
  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam logic [7:0] TAG_BITS = 8'h10;
  localparam logic [7:0] SLOT_BITS = 8'h14;
  localparam logic [7:0] FRAME_LAST = 8'hFF;
  localparam int NSLOT = 13;
  localparam int SLOT_W = 20;
  localparam logic [3:0] SLOT_TAG = 4'h0;
  localparam logic [3:0] SLOT_CMD = 4'h1;
  localparam logic [3:0] SLOT_DATA = 4'h2;
  localparam logic [3:0] SLOT_MODEM = 4'h5;
  localparam logic [3:0] SLOT_HSET = 4'hB;
  localparam logic [3:0] SLOT_GPIO = 4'hC;
  localparam int TAG_READY = 15;
  localparam int TAG_CMD = 14;
  localparam int TAG_DATA = 13;
  localparam int TAG_MODEM = 10;
  localparam int TAG_HSET = 4;
  localparam int TAG_GPIO = 3;
  localparam int RW_BIT = 19;
  localparam int IDX_MSB = 18;
  localparam int IDX_LSB = 12;
  localparam int DAT_MSB = 19;
  localparam int DAT_LSB = 4;
  localparam int LOW_W = 4;
  localparam int IDX_PAD_W = 12;
  localparam int GPIO_W = 16;
  localparam int GPIO_USED = 7;
  localparam int GPIO_EXT_LO = 4;
  localparam int GPIO_EXT_N = 3;
  localparam int NREG = 64;
  // Configuration word: bit n set makes GPIO n an output
  localparam logic [6:0] GPIO_CFG_INDEX = 7'h4C;
  // ************************************************************
  // Controller register map
  // ************************************************************
  localparam int AW = 12;
  localparam logic [AW-1:0] A_CMD = 12'h000;
  localparam logic [AW-1:0] A_STATUS = 12'h004;
  localparam logic [AW-1:0] A_RDATA = 12'h008;
  localparam logic [AW-1:0] A_DAC = 12'h00C;
  localparam logic [AW-1:0] A_GPCTL = 12'h010;
  localparam logic [AW-1:0] A_ADC = 12'h014;
  localparam logic [AW-1:0] A_GPSTAT = 12'h018;
  localparam int CMD_READ_BIT = 23;
  localparam int CMD_IDX_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_RDY = 1;

  typedef logic [NSLOT-1:0][SLOT_W-1:0] acm_frame_type;

  // Slot number of frame bit i
  function automatic logic [3:0] acm_slot_of(input logic [7:0] i);
    if (i < TAG_BITS) begin
      return SLOT_TAG;
    end
    return 4'((i - TAG_BITS) / SLOT_BITS + 8'h01);
  endfunction : acm_slot_of

  // Bit position inside its slot, MSB sent first
  function automatic logic [4:0] acm_pos_of(input logic [7:0] i);
    if (i < TAG_BITS) begin
      return 5'(TAG_BITS - 8'h01 - i);
    end
    return 5'(SLOT_BITS - 8'h01 - ((i - TAG_BITS) % SLOT_BITS));
  endfunction : acm_pos_of
endpackage : acm_pkg

// ---- rtl/acm_link_if.sv ----
// AC-link serial wires joining the codec end and the controller end
`timescale 1ns/1ps
interface acm_link_if;
  logic bit_clk;
  logic sync;
  logic sdata_out;
  logic sdata_in;
  modport codec (output bit_clk, output sdata_in, input sync, input sdata_out);
  modport ctrl (input bit_clk, input sdata_in, output sync, output sdata_out);
endinterface : acm_link_if

// ---- rtl/acm_codec.sv ----
// Codec end: bit clock divider, slot payload packing and command register file
`timescale 1ns/1ps
module acm_codec
  import acm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  acm_link_if.codec link,
  input wire logic [15:0] adc_sample,
  input wire logic [15:0] hset_sample,
  output logic [15:0] dac_sample,
  output logic dac_valid,
  input wire logic line_current_loss,
  input wire logic ring_detect,
  input wire logic ring_polarity_reversal_detect,
  input wire logic supply_voltage_monitor,
  input wire logic [GPIO_EXT_N-1:0] ext_gpio_in,
  output logic [GPIO_EXT_N-1:0] ext_gpio_out,
  output logic [GPIO_EXT_N-1:0] ext_gpio_oe_n
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic bclk;
    logic sync_a;
    logic sync_b;
    logic sdo_a;
    logic sdo_b;
    logic sync_prev;
    logic locked;
    logic [7:0] idx;
    logic [SLOT_W-1:0] sh;
    acm_frame_type rx;
    acm_frame_type tx;
    logic sdi;
    logic [NREG-1:0][15:0] regs;
    logic [GPIO_USED-1:0] gin_a;
    logic [GPIO_USED-1:0] gin_b;
    logic [GPIO_W-1:0] gctl;
    logic [GPIO_EXT_N-1:0] ext_out;
    logic [GPIO_EXT_N-1:0] ext_oe_n;
    logic [15:0] dac;
    logic dac_valid;
  } acm_codec_state_type;

  acm_codec_state_type s;
  acm_codec_state_type next_s;

  // ************************************************************
  // Combined next-state logic
  // ************************************************************
  always_comb begin
    logic [7:0] bit_idx;
    logic [3:0] slot;
    logic [4:0] pos;
    logic [SLOT_W-1:0] c1;
    logic [SLOT_W-1:0] c2;
    logic [15:0] tag;
    logic [15:0] cfg;
    logic [GPIO_USED-1:0] gstat;
    logic resp;
    logic [6:0] ridx;
    logic [15:0] rdat;
    bit_idx = '0;
    slot = '0;
    pos = '0;
    c1 = '0;
    c2 = '0;
    tag = '0;
    cfg = '0;
    gstat = '0;
    resp = 1'b0;
    ridx = '0;
    rdat = '0;
    next_s = s;
    next_s.dac_valid = 1'b0;
    // Pins from the link and the line side are asynchronous here
    next_s.sync_a = link.sync;
    next_s.sync_b = s.sync_a;
    next_s.sdo_a = link.sdata_out;
    next_s.sdo_b = s.sdo_a;
    next_s.gin_a = {ext_gpio_in, supply_voltage_monitor,
                    ring_polarity_reversal_detect, ring_detect, line_current_loss};
    next_s.gin_b = s.gin_a;
    next_s.div = s.div + DIV_W'(1);
    if (s.div == DIV_LAST) begin
      next_s.div = '0;
      next_s.bclk = ~s.bclk;
      if (!s.bclk) begin
        // Rising edge: present the next bit, nothing before first lock
        bit_idx = s.idx + 8'h01;
        slot = acm_slot_of(bit_idx);
        pos = acm_pos_of(bit_idx);
        next_s.sdi = s.locked & s.tx[slot][pos];
      end else begin
        // Falling edge: sample the controller's bit
        next_s.sync_prev = s.sync_b;
        if (s.sync_b && !s.sync_prev) begin
          next_s.idx = '0;
          next_s.locked = 1'b1;
        end else begin
          next_s.idx = s.idx + 8'h01;
        end
        slot = acm_slot_of(next_s.idx);
        pos = acm_pos_of(next_s.idx);
        next_s.sh = {s.sh[SLOT_W-2:0], s.sdo_b};
        if (pos == '0) begin
          next_s.rx[slot] = next_s.sh;
        end
        if (next_s.idx == FRAME_LAST && s.locked) begin
          tag = next_s.rx[SLOT_TAG][15:0];
          c1 = next_s.rx[SLOT_CMD];
          c2 = next_s.rx[SLOT_DATA];
          cfg = s.regs[GPIO_CFG_INDEX[6:1]];
          if (tag[TAG_CMD]) begin
            ridx = c1[IDX_MSB:IDX_LSB]; // see RULE_14
            if (c1[RW_BIT]) begin // see RULE_13
              // Answer goes into the very next frame; a write in that
              // frame cannot change the value already captured here
              resp = 1'b1; // see RULE_20
              rdat = s.regs[ridx[6:1]];
            end else if (tag[TAG_DATA]) begin
              next_s.regs[ridx[6:1]] = c2[DAT_MSB:DAT_LSB]; // see RULE_16, RULE_19
            end
          end
          if (tag[TAG_MODEM]) begin
            next_s.dac = next_s.rx[SLOT_MODEM][DAT_MSB:DAT_LSB]; // see RULE_18
            next_s.dac_valid = 1'b1;
          end
          if (tag[TAG_GPIO]) begin
            next_s.gctl = next_s.rx[SLOT_GPIO][DAT_MSB:DAT_LSB];
          end
          for (int i = 0; i < GPIO_USED; i++) begin
            // Outputs echo the command, inputs show the sampled level
            gstat[i] = cfg[i] ? next_s.gctl[i] : s.gin_b[i]; // see RULE_07, RULE_08
          end
          next_s.tx = '0;
          next_s.tx[SLOT_TAG][TAG_READY] = 1'b1;
          next_s.tx[SLOT_TAG][TAG_CMD] = resp; // see RULE_21
          next_s.tx[SLOT_TAG][TAG_DATA] = resp; // see RULE_21
          next_s.tx[SLOT_TAG][TAG_MODEM] = 1'b1; // see RULE_05
          next_s.tx[SLOT_TAG][TAG_HSET] = 1'b1;
          next_s.tx[SLOT_TAG][TAG_GPIO] = 1'b1; // see RULE_05
          if (resp) begin
            next_s.tx[SLOT_CMD][IDX_MSB:IDX_LSB] = ridx; // see RULE_22
            next_s.tx[SLOT_DATA][DAT_MSB:DAT_LSB] = rdat; // see RULE_01, RULE_02
          end
          next_s.tx[SLOT_MODEM] = {adc_sample, LOW_W'(0)}; // see RULE_03, RULE_04
          next_s.tx[SLOT_HSET] = {hset_sample, LOW_W'(0)}; // see RULE_06, RULE_04
          // Positions 19:11 have no pin behind them and stay zero
          next_s.tx[SLOT_GPIO][DAT_LSB +: GPIO_USED] = gstat; // see RULE_10, RULE_11, RULE_12
        end
      end
    end
    // Only the companion's external pins can actually be driven
    next_s.ext_out = next_s.gctl[GPIO_EXT_LO +: GPIO_EXT_N]; // see RULE_23
    next_s.ext_oe_n = ~s.regs[GPIO_CFG_INDEX[6:1]][GPIO_EXT_LO +: GPIO_EXT_N];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ext_oe_n <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.bit_clk = s.bclk;
  assign link.sdata_in = s.sdi;
  assign dac_sample = s.dac;
  assign dac_valid = s.dac_valid;
  assign ext_gpio_out = s.ext_out;
  assign ext_gpio_oe_n = s.ext_oe_n;
endmodule : acm_codec

// ---- rtl/acm_ctrl.sv ----
// Controller end: APB register slave that frames commands and samples on the AC-link
`timescale 1ns/1ps
module acm_ctrl
  import acm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  acm_link_if.ctrl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic bc_a;
    logic bc_b;
    logic bc_prev;
    logic sdi_a;
    logic sdi_b;
    logic [7:0] idx;
    logic [SLOT_W-1:0] sh;
    acm_frame_type rx;
    acm_frame_type tx;
    logic sync;
    logic sdo;
    logic pend;
    logic cmd_rd;
    logic [6:0] cmd_idx;
    logic [15:0] cmd_wd;
    logic [15:0] dac;
    logic [GPIO_W-1:0] gctl;
    logic rd_flag;
    logic [6:0] rd_idx;
    logic [15:0] rd_data;
    logic [15:0] adc;
    logic [15:0] hset;
    logic [GPIO_W-1:0] gstat;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acm_ctrl_state_type;

  acm_ctrl_state_type s;
  acm_ctrl_state_type next_s;

  always_comb begin
    logic [3:0] slot;
    logic [4:0] pos;
    logic [15:0] tag;
    logic rd_set;
    logic wr_cmd;
    slot = '0;
    pos = '0;
    tag = '0;
    rd_set = 1'b0;
    wr_cmd = 1'b0;
    next_s = s;
    next_s.bc_a = link.bit_clk;
    next_s.bc_b = s.bc_a;
    next_s.bc_prev = s.bc_b;
    next_s.sdi_a = link.sdata_in;
    next_s.sdi_b = s.sdi_a;
    // ************************************************************
    // Link side, stepped by the sampled bit clock
    // ************************************************************
    if (s.bc_b && !s.bc_prev) begin
      next_s.idx = s.idx + 8'h01;
      slot = acm_slot_of(next_s.idx);
      pos = acm_pos_of(next_s.idx);
      next_s.sync = next_s.idx < TAG_BITS;
      next_s.sdo = s.tx[slot][pos];
    end else if (!s.bc_b && s.bc_prev) begin
      slot = acm_slot_of(s.idx);
      pos = acm_pos_of(s.idx);
      next_s.sh = {s.sh[SLOT_W-2:0], s.sdi_b};
      if (pos == '0) begin
        next_s.rx[slot] = next_s.sh;
      end
      if (s.idx == FRAME_LAST) begin
        tag = next_s.rx[SLOT_TAG][15:0];
        if (tag[TAG_CMD] && tag[TAG_DATA]) begin
          rd_set = 1'b1;
          next_s.rd_idx = next_s.rx[SLOT_CMD][IDX_MSB:IDX_LSB];
          next_s.rd_data = next_s.rx[SLOT_DATA][DAT_MSB:DAT_LSB];
        end
        if (tag[TAG_MODEM]) begin
          next_s.adc = next_s.rx[SLOT_MODEM][DAT_MSB:DAT_LSB];
        end
        if (tag[TAG_HSET]) begin
          next_s.hset = next_s.rx[SLOT_HSET][DAT_MSB:DAT_LSB];
        end
        // Raw once-per-frame levels; software debounces them
        if (tag[TAG_GPIO]) begin
          next_s.gstat = next_s.rx[SLOT_GPIO][DAT_MSB:DAT_LSB]; // see RULE_09
        end
        next_s.tx = '0;
        next_s.tx[SLOT_TAG][TAG_READY] = 1'b1;
        next_s.tx[SLOT_TAG][TAG_CMD] = s.pend;
        next_s.tx[SLOT_TAG][TAG_DATA] = s.pend & ~s.cmd_rd;
        next_s.tx[SLOT_TAG][TAG_MODEM] = 1'b1;
        next_s.tx[SLOT_TAG][TAG_GPIO] = 1'b1;
        if (s.pend) begin
          // Low twelve bits stay zero
          next_s.tx[SLOT_CMD] = {s.cmd_rd, s.cmd_idx, IDX_PAD_W'(0)}; // see RULE_13, RULE_14, RULE_15
          // A read leaves the whole data slot at zero
          if (!s.cmd_rd) begin // see RULE_17
            next_s.tx[SLOT_DATA] = {s.cmd_wd, LOW_W'(0)}; // see RULE_16, RULE_19
          end
        end
        next_s.tx[SLOT_MODEM] = {s.dac, LOW_W'(0)}; // see RULE_18
        next_s.tx[SLOT_GPIO] = {s.gctl, LOW_W'(0)};
        next_s.pend = 1'b0;
      end
    end
    // ************************************************************
    // APB slave, one wait-free access phase
    // ************************************************************
    next_s.pready = psel & ~penable;
    if (psel && !penable) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      unique case (paddr)
        A_CMD: next_s.prdata = {8'h00, s.cmd_rd, s.cmd_idx, s.cmd_wd};
        A_STATUS: next_s.prdata = {30'h0, s.rd_flag, s.pend};
        A_RDATA: next_s.prdata = {9'h000, s.rd_idx, s.rd_data};
        A_DAC: next_s.prdata = {16'h0000, s.dac};
        A_GPCTL: next_s.prdata = {16'h0000, s.gctl};
        A_ADC: next_s.prdata = {s.hset, s.adc};
        A_GPSTAT: next_s.prdata = {16'h0000, s.gstat};
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && !s.pslverr) begin
      if (pwrite) begin
        unique case (paddr)
          A_CMD: wr_cmd = 1'b1;
          A_DAC: next_s.dac = pwdata[15:0];
          A_GPCTL: next_s.gctl = pwdata[GPIO_W-1:0];
          default: ;
        endcase
      end else if (paddr == A_RDATA && !rd_set) begin
        // A fresh result in the same cycle beats the clear
        next_s.rd_flag = 1'b0;
      end
    end
    if (rd_set) begin
      next_s.rd_flag = 1'b1;
    end
    // A new command written as a frame closes still waits for the next one
    if (wr_cmd) begin
      next_s.pend = 1'b1;
      next_s.cmd_rd = pwdata[CMD_READ_BIT];
      next_s.cmd_idx = pwdata[CMD_IDX_LSB +: 7];
      next_s.cmd_wd = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.idx <= FRAME_LAST;
    end else begin
      s <= next_s;
    end
  end

  assign link.sync = s.sync;
  assign link.sdata_out = s.sdo;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
endmodule : acm_ctrl

// ---- verif/acm_link_properties.sv ----
// Link-level assertions watching the AC-link wires between both ends
`timescale 1ns/1ps
module acm_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_clk,
  input wire logic sync,
  input wire logic sdata_out,
  input wire logic sdata_in
);
  // ****************
  // Frame position tracking
  // ****************
  logic clk_last;
  logic sync_last;
  logic locked;
  logic out_tag;
  logic out_read;
  logic prev_read;
  logic in_tag1;
  logic [7:0] idx;
  logic [6:0] out_idx;
  logic [6:0] prev_idx;
  logic fall;
  logic start;
  logic [7:0] cur;
  logic [3:0] slot;
  logic [4:0] pos;
  // Bits are judged at the falling bit clock, where both ends hold them steady
  assign fall = clk_last && !bit_clk;
  assign start = fall && sync && !sync_last;
  assign cur = start ? 8'h00 : idx + 8'h01;
  assign slot = (cur < 8'h10) ? 4'h0 : 4'((cur - 8'h10) / 8'h14 + 8'h01);
  assign pos = (cur < 8'h10) ? 5'(8'h0F - cur) : 5'(8'h13 - (cur - 8'h10) % 8'h14);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_last <= 1'b0;
      sync_last <= 1'b0;
      locked <= 1'b0;
      out_tag <= 1'b0;
      out_read <= 1'b0;
      prev_read <= 1'b0;
      in_tag1 <= 1'b0;
      idx <= 8'h00;
      out_idx <= 7'h00;
      prev_idx <= 7'h00;
    end else begin
      clk_last <= bit_clk;
      if (fall) begin
        sync_last <= sync;
        idx <= cur;
        if (start) begin
          locked <= 1'b1;
          prev_read <= out_read;
          prev_idx <= out_idx;
        end
        if (cur == 8'h01) begin
          out_tag <= sdata_out;
          in_tag1 <= sdata_in;
        end
        if (slot == 4'h1 && pos == 5'h13) begin
          out_read <= out_tag && sdata_out;
        end
        if (slot == 4'h1 && pos >= 5'h0C && pos <= 5'h12) begin
          out_idx[pos - 5'h0C] <= sdata_out;
        end
      end
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_live;
    fall && locked;
  endsequence
  sequence s_in_nibble;
    s_live ##0 (pos < 5'h04 && (slot == 4'h2 || slot == 4'h5 || slot == 4'hB || slot == 4'hC));
  endsequence
  a_in_nibble_zero:
    assert property (s_in_nibble |-> !sdata_in) else $error("incoming low nibble not zero");
  a_gpio_unused_zero:
    assert property (s_live ##0 (slot == 4'hC && pos >= 5'h0B) |-> !sdata_in)
      else $error("unsupported status bit set");
  a_tag_pair_match:
    assert property (s_live ##0 cur == 8'h02 |-> sdata_in == in_tag1)
      else $error("slot 1 and slot 2 tags differ");
  a_reply_next_frame:
    assert property (s_live ##0 cur == 8'h01 |-> sdata_in == prev_read)
      else $error("read reply not in following frame");
  a_index_echo:
    assert property (s_live ##0 (slot == 4'h1 && pos >= 5'h0C && pos <= 5'h12)
      |-> sdata_in == (prev_read && prev_idx[pos - 5'h0C])) else $error("index echo wrong");
  a_data_idle_zero:
    assert property (s_live ##0 (slot == 4'h2 && !prev_read) |-> !sdata_in)
      else $error("status data not zero while invalid");
  a_cmd_pad_zero:
    assert property (s_live ##0 (slot == 4'h1 && pos < 5'h0C) |-> !sdata_out)
      else $error("command slot padding not zero");
  a_read_data_zero:
    assert property (s_live ##0 (slot == 4'h2 && out_read) |-> !sdata_out)
      else $error("command data not zero on read");
  a_out_nibble_zero:
    assert property (s_live ##0 ((slot == 4'h2 || slot == 4'h5) && pos < 5'h04) |-> !sdata_out)
      else $error("outgoing low nibble not zero");
endmodule : acm_link_properties

// ---- verif/test_aclink_modem_slot_payloads.sv ----
// Testbench joining codec and controller ends over the AC-link
`timescale 1ns/1ps
module test_aclink_modem_slot_payloads;
  import acm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] adc_sample = 16'h0000;
  logic [15:0] hset_sample = 16'h0000;
  logic [15:0] dac_sample;
  logic dac_valid;
  logic line_current_loss = 1'b0;
  logic ring_detect = 1'b0;
  logic ring_polarity_reversal_detect = 1'b0;
  logic supply_voltage_monitor = 1'b0;
  logic [2:0] ext_gpio_in = 3'h0;
  logic [2:0] ext_gpio_out;
  logic [2:0] ext_gpio_oe_n;
  int miscompares = 0;
  int check_count = 0;
  acm_link_if link ();
  acm_codec u_acm_codec (.pclk(pclk), .presetn(presetn), .link(link), .adc_sample(adc_sample),
    .hset_sample(hset_sample), .dac_sample(dac_sample), .dac_valid(dac_valid),
    .line_current_loss(line_current_loss), .ring_detect(ring_detect),
    .ring_polarity_reversal_detect(ring_polarity_reversal_detect),
    .supply_voltage_monitor(supply_voltage_monitor), .ext_gpio_in(ext_gpio_in),
    .ext_gpio_out(ext_gpio_out), .ext_gpio_oe_n(ext_gpio_oe_n));
  acm_ctrl u_acm_ctrl (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  acm_link_properties chk_link (.pclk(pclk), .presetn(presetn), .bit_clk(link.bit_clk),
    .sync(link.sync), .sdata_out(link.sdata_out), .sdata_in(link.sdata_in));
  always #(PCLK_PERIOD_NS / 2) pclk = ~pclk;
  // ****************
  // Bus and compare helpers
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read right after the edge are those the edge sampled
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : rd
  // Polls until the masked value matches; running out counts as a mismatch
  task automatic wait_reg(input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] x,
                          output logic [31:0] d);
    for (int i = 0; i < 6000; i++) begin
      rd(a, d);
      if ((d & m) === x) begin
        break;
      end
    end
    check(d & m, x);
  endtask : wait_reg
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // ****************
  // Scenarios
  // ****************
  task automatic t_apb_map;
    logic [31:0] d;
    logic e;
    apb(1'b0, 12'h01C, 32'h0, d, e);
    check(d, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(A_ADC, 32'hFFFFFFFF);
    rd(A_ADC, d);
    check(d, 32'h0);
    rd(A_STATUS, d);
    check(d, 32'h0);
  endtask : t_apb_map
  task automatic t_samples;
    logic [31:0] d;
    int n;
    n = 0;
    @(posedge pclk);
    adc_sample <= 16'h8001;
    hset_sample <= 16'h7FFE;
    wr(A_DAC, 32'h0000A5C3);
    rd(A_DAC, d);
    check(d, 32'h0000A5C3);
    wait_reg(A_ADC, 32'hFFFFFFFF, 32'h7FFE8001, d);
    check(d, 32'h7FFE8001);
    while (!(dac_valid === 1'b1 && dac_sample === 16'hA5C3) && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, dac_valid}, 32'h1);
    check({16'h0000, dac_sample}, 32'h0000A5C3);
  endtask : t_samples
  task automatic t_commands;
    logic [31:0] d;
    logic [6:0] ix [2] = '{7'h10, 7'h7E};
    logic [15:0] dat [2] = '{16'h1234, 16'hFEDC};
    for (int i = 0; i < 2; i++) begin
      wr(A_CMD, {9'h000, ix[i], dat[i]});
      wait_reg(A_STATUS, 32'h1, 32'h0, d);
    end
    for (int i = 0; i < 2; i++) begin
      wr(A_CMD, {8'h00, 1'b1, ix[i], 16'h0000});
      rd(A_CMD, d);
      check(d, {8'h00, 1'b1, ix[i], 16'h0000});
      wait_reg(A_STATUS, 32'h2, 32'h2, d);
      check(d & 32'h2, 32'h2);
      rd(A_RDATA, d);
      check(d, {9'h000, ix[i], dat[i]});
      rd(A_STATUS, d);
      check(d & 32'h2, 32'h0);
    end
  endtask : t_commands
  task automatic t_gpio_in;
    logic [31:0] d;
    logic [6:0] pat [2] = '{7'h6D, 7'h12};
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      {ext_gpio_in, supply_voltage_monitor, ring_polarity_reversal_detect, ring_detect,
       line_current_loss} <= pat[i];
      wait_reg(A_GPSTAT, 32'hFFFF, {25'h0, pat[i]}, d);
      check(d & 32'hFFFF, {25'h0, pat[i]});
    end
  endtask : t_gpio_in
  task automatic t_gpio_out;
    logic [31:0] d;
    wr(A_CMD, {9'h000, GPIO_CFG_INDEX, 16'h0070});
    wait_reg(A_STATUS, 32'h1, 32'h0, d);
    wr(A_GPCTL, 32'h00000050);
    rd(A_GPCTL, d);
    check(d, 32'h00000050);
    @(posedge pclk);
    ext_gpio_in <= 3'h2;
    wait_reg(A_GPSTAT, 32'h70, 32'h50, d);
    check(d & 32'h70, 32'h50);
    check({29'h0, ext_gpio_out}, 32'h5);
    check({29'h0, ext_gpio_oe_n}, 32'h0);
  endtask : t_gpio_out
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_apb_map();
    t_samples();
    t_commands();
    t_gpio_in();
    t_gpio_out();
    close_out();
  end
  // Sized for roughly twenty frames of traffic with margin
  initial begin
    repeat (95000) @(posedge pclk);
    miscompares++;
    close_out();
  end
endmodule : test_aclink_modem_slot_payloads
